//--- hdl/nvm_ctrl.sv
`timescale 1ns/10ps
// Operation
// - 256-byte array, 8-bit pointer 00h-FFh.
// - Data-space writes erase then program, self-timed.
// - Unlock port stores nothing, reads zero.
// - Read/write triggers set-only, hardware clears.
// - Write needs 55h, AAh, then trigger.
// - Write trigger refused unless arm set.
// - Clearing arm mid-write does not abort.
// - Completing a write never clears arm; pin/watchdog reset does.
// - Finish clears trigger, sets sticky done flag unless it is already set and cleared that cycle.
// - Pin/watchdog reset mid-write sets abort flag.
// - Abort keeps code-space and row-erase bits.
// - Aborting reset zeroes data and pointer.
// - Data read loads latch next cycle.
// - Read trigger blocked when code-space set.
// - Latch holds until next read or write.
// - Bits 7/6 select flash or config space.
// - Row-erase bit erases row, hardware clears.
// - Arm cleared at power-up; timer blocks writes.
module nvm_ctrl #(
   parameter int PWRT_CYCLES = nvm_pkg::NVM_PWRT_CYCLES,
   parameter int ERASE_CYCLES = nvm_pkg::NVM_ERASE_CYCLES_DEF,
   parameter int PROGRAM_CYCLES = nvm_pkg::NVM_PROGRAM_CYCLES_DEF
)
(
   // Clock and resets.
   input wire logic clk,
   input wire logic nrst,
   input wire logic por,
   input wire logic external_reset_pin,
   input wire logic watchdog_timeout,
   // Register port from the core.
   input wire logic [1:0] reg_sel,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Done flag and its software clear.
   input wire logic done_clear,
   output logic nvm_done_flag,
   // Hand-off to the program-memory sequencer.
   output logic pm_read_req,
   output logic pm_write_req,
   output logic [1:0] pm_space,
   output logic pm_row_erase,
   input wire logic pm_done,
   output logic busy
);
   import nvm_pkg::*;

   typedef struct packed {
      logic [7:0] ptr;
      logic [7:0] data;
      logic code_sel;
      logic cfg_sel;
      logic row_erase;
      logic abort;
      logic arm;
      logic wr;
      logic rd;
      logic done;
      nvm_state_e st;
      nvm_unlock_e ul;
      logic [31:0] tmr;
      logic [31:0] pwrt;
      logic pm_busy;
      logic pm_rreq;
      logic pm_wreq;
      logic [7:0] rdata;
      logic mem_we;
   } nvm_state_s;

   nvm_state_s r;
   nvm_state_s next_r;
   logic [7:0] arr_rdata;
   logic ext_meta;
   logic ext_sync;
   logic wdt_meta;
   logic wdt_sync;
   logic abort_reset;
   logic data_space;

   ////////////////////////////////////////////////////////////////////////////
   // Reset request pins come from outside; two flops before use.
   // The two flops add two cycles of latency before a running write is cut.
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
         wdt_meta <= 1'b0;
         wdt_sync <= 1'b0;
      end
      else
      begin
         ext_meta <= external_reset_pin;
         ext_sync <= ext_meta;
         wdt_meta <= watchdog_timeout;
         wdt_sync <= wdt_meta;
      end
   end

   assign abort_reset = ext_sync | wdt_sync;
   assign data_space = !r.code_sel && !r.cfg_sel;

   // The array keeps its contents through every reset of this block.
   nvm_array u_array
   (
      .clk(clk),
      .we(r.mem_we),
      .waddr(r.ptr),
      .wdata(r.data),
      .raddr(r.ptr),
      .rdata(arr_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic: register writes, unlock tracking, write sequencer.
   always_comb
   begin
      logic busy_now;
      logic set_wr;
      logic set_rd;
      busy_now = 1'b0;
      set_wr = 1'b0;
      set_rd = 1'b0;
      next_r = r;
      next_r.mem_we = 1'b0;
      next_r.pm_rreq = 1'b0;
      next_r.pm_wreq = 1'b0;
      busy_now = (r.st != NVM_ST_IDLE) || r.pm_busy;
      if (r.pwrt != 32'h0)
      begin
         next_r.pwrt = r.pwrt - 32'h1;
      end

      // Register writes from the core.
      if (reg_wr)
      begin
         unique case (reg_sel)
            NVM_SEL_POINTER:
            begin
               next_r.ptr = reg_wdata;
            end
            NVM_SEL_DATA:
            begin
               next_r.data = reg_wdata;
            end
            NVM_SEL_UNLOCK:
            begin
               // Only an exact 55h then AAh pair opens the gate.
               if (reg_wdata == NVM_KEY_FIRST)
               begin
                  next_r.ul = NVM_UL_FIRST;
               end
               else if (reg_wdata == NVM_KEY_SECOND && r.ul == NVM_UL_FIRST)
               begin
                  next_r.ul = NVM_UL_OPEN;
               end
               else
               begin
                  next_r.ul = NVM_UL_NONE;
               end
            end
            NVM_SEL_CONTROL:
            begin
               next_r.code_sel = reg_wdata[NVM_BIT_CODE];
               next_r.cfg_sel = reg_wdata[NVM_BIT_CFG];
               next_r.row_erase = reg_wdata[NVM_BIT_ROW_ERASE];
               next_r.abort = reg_wdata[NVM_BIT_ABORT];
               next_r.arm = reg_wdata[NVM_BIT_ARM];
               // Write trigger needs arm already set before this write.
               set_wr = reg_wdata[NVM_BIT_WR] && r.arm && !r.wr && r.ul == NVM_UL_OPEN;
               // The code bit in this same write counts, so one write cannot select code space and read.
               set_rd = reg_wdata[NVM_BIT_RD] && !reg_wdata[NVM_BIT_CODE] && !r.rd && !busy_now;
               next_r.ul = NVM_UL_NONE;
            end
            default:
            begin
               next_r.ul = r.ul;
            end
         endcase
      end

      // A read in the data space completes in the following cycle.
      if (r.rd)
      begin
         next_r.rd = 1'b0;
         if (data_space)
         begin
            next_r.data = arr_rdata;
         end
      end
      if (set_rd)
      begin
         next_r.rd = 1'b1;
         if (next_r.code_sel || next_r.cfg_sel)
         begin
            next_r.pm_rreq = 1'b1;
         end
      end

      // Start a write; power-up timer blocks it outright.
      if (set_wr && r.pwrt == 32'h0)
      begin
         next_r.wr = 1'b1;
         next_r.tmr = 32'h0;
         if (!next_r.code_sel && !next_r.cfg_sel)
         begin
            next_r.st = NVM_ST_ERASE;
         end
         else
         begin
            next_r.pm_busy = 1'b1;
            next_r.pm_wreq = 1'b1;
         end
      end

      // Self-timed sequencer; arm is not consulted once started.
      // Limitation: erase and program times are fixed counts and do not track supply or temperature.
      unique case (r.st)
         NVM_ST_IDLE:
         begin
            next_r.tmr = (set_wr) ? 32'h0 : r.tmr;
         end
         NVM_ST_ERASE:
         begin
            if (r.tmr == 32'(ERASE_CYCLES - 1))
            begin
               next_r.tmr = 32'h0;
               next_r.st = NVM_ST_PROGRAM;
            end
            else
            begin
               next_r.tmr = r.tmr + 32'h1;
            end
         end
         NVM_ST_PROGRAM:
         begin
            if (r.tmr == 32'(PROGRAM_CYCLES - 1))
            begin
               next_r.mem_we = 1'b1;
               next_r.st = NVM_ST_IDLE;
               next_r.wr = 1'b0;
               next_r.done = 1'b1;
            end
            else
            begin
               next_r.tmr = r.tmr + 32'h1;
            end
         end
      endcase

      // Program-memory sequencer reports completion.
      if (r.pm_busy && pm_done)
      begin
         next_r.pm_busy = 1'b0;
         next_r.wr = 1'b0;
         next_r.row_erase = 1'b0;
         next_r.done = 1'b1;
      end

      // Software clear loses to a completion in the same cycle only while done is still clear; if done is already set, the clear wins.
      if (done_clear && !(next_r.done && !r.done))
      begin
         next_r.done = 1'b0;
      end

      // Read-back mux; the unlock port has no storage.
      unique case (reg_sel)
         NVM_SEL_POINTER: next_r.rdata = r.ptr;
         NVM_SEL_DATA: next_r.rdata = r.data;
         NVM_SEL_UNLOCK: next_r.rdata = 8'h00;
         NVM_SEL_CONTROL: next_r.rdata = {r.code_sel, r.cfg_sel, 1'b0, r.row_erase,
                                          r.abort, r.arm, r.wr, r.rd};
      endcase
      if (!reg_rd)
      begin
         next_r.rdata = r.rdata;
      end

      // Pin or watchdog reset: abort any running write.
      if (abort_reset)
      begin
         next_r.abort = next_r.abort | ((r.st != NVM_ST_IDLE) || r.pm_busy);
         next_r.ptr = 8'h00;
         next_r.data = 8'h00;
         next_r.st = NVM_ST_IDLE;
         next_r.mem_we = 1'b0;
         next_r.wr = 1'b0;
         next_r.rd = 1'b0;
         next_r.pm_busy = 1'b0;
         next_r.pm_rreq = 1'b0;
         next_r.pm_wreq = 1'b0;
         next_r.ul = NVM_UL_NONE;
         next_r.arm = 1'b0;
         next_r.tmr = 32'h0;
         next_r.code_sel = r.code_sel;
         next_r.row_erase = r.row_erase;
         // A cut write must never report completion, even in its last cycle.
         if (!r.done)
         begin
            next_r.done = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register. Power-on clears arm and restarts the power-up timer.
   // The array itself is not touched here, so its contents survive every reset.
   always_ff @(posedge clk)
   begin
      if (!nrst || por)
      begin
         r <= '0;
         r.arm <= 1'b0;
         r.st <= NVM_ST_IDLE;
         r.ul <= NVM_UL_NONE;
         r.pwrt <= 32'(PWRT_CYCLES);
      end
      else
      begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register.
   // Busy mirrors the write trigger, so software and the sequencer watch one bit.
   assign reg_rdata = r.rdata;
   assign nvm_done_flag = r.done;
   assign pm_read_req = r.pm_rreq;
   assign pm_write_req = r.pm_wreq;
   assign pm_space = {r.code_sel, r.cfg_sel};
   assign pm_row_erase = r.row_erase;
   assign busy = r.wr;
endmodule // nvm_ctrl

//--- include/nvm_pkg.sv
package nvm_pkg;
   // Register select codes on the special function register port.
   localparam logic [1:0] NVM_SEL_CONTROL = 2'h0;
   localparam logic [1:0] NVM_SEL_UNLOCK = 2'h1;
   localparam logic [1:0] NVM_SEL_DATA = 2'h2;
   localparam logic [1:0] NVM_SEL_POINTER = 2'h3;
   // Control register field positions.
   localparam int NVM_BIT_RD = 0;
   localparam int NVM_BIT_WR = 1;
   localparam int NVM_BIT_ARM = 2;
   localparam int NVM_BIT_ABORT = 3;
   localparam int NVM_BIT_ROW_ERASE = 4;
   localparam int NVM_BIT_CFG = 6;
   localparam int NVM_BIT_CODE = 7;
   // Unlock key bytes.
   localparam logic [7:0] NVM_KEY_FIRST = 8'h55;
   localparam logic [7:0] NVM_KEY_SECOND = 8'haa;
   // Array geometry.
   localparam int NVM_DEPTH = 256;
   localparam int NVM_AW = 8;
   // Clock and timing figures.
   localparam int NVM_CLK_MHZ = 250;
   localparam int NVM_PWRT_MS = 72;
   localparam int NVM_PWRT_CYCLES = NVM_PWRT_MS * NVM_CLK_MHZ * 1000;
   localparam int NVM_ERASE_CYCLES_DEF = 1000;
   localparam int NVM_PROGRAM_CYCLES_DEF = 1000;
   // Write sequencer states.
   typedef enum logic [2:0]
   {
      NVM_ST_IDLE = 3'b001,
      NVM_ST_ERASE = 3'b010,
      NVM_ST_PROGRAM = 3'b100
   } nvm_state_e;
   // Unlock tracker states.
   typedef enum logic [2:0]
   {
      NVM_UL_NONE = 3'b001,
      NVM_UL_FIRST = 3'b010,
      NVM_UL_OPEN = 3'b100
   } nvm_unlock_e;
endpackage

//--- hdl/nvm_array.sv
`timescale 1ns/10ps
// Byte array with one write port and a combinational read port.
module nvm_array
(
   // Clock.
   input wire logic clk,
   // Write side.
   input wire logic we,
   input wire logic [nvm_pkg::NVM_AW-1:0] waddr,
   input wire logic [7:0] wdata,
   // Read side.
   input wire logic [nvm_pkg::NVM_AW-1:0] raddr,
   output logic [7:0] rdata
);
   import nvm_pkg::*;

   logic [7:0] mem [NVM_DEPTH];

   ////////////////////////////////////////////////////////////////////////////
   // Contents persist across reset, as a nonvolatile array must.
   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata = mem[raddr];
endmodule // nvm_array

//--- testbench/nvm_ctrl_checker.sv
`timescale 1ns/10ps
// Port-level timing and refusal checks for the control block.
module nvm_ctrl_checker
   import nvm_pkg::*;
#(
   parameter int PWRT_CYCLES = 10
)
(
   // Clock and resets.
   input wire logic clk,
   input wire logic nrst,
   input wire logic por,
   input wire logic external_reset_pin,
   input wire logic watchdog_timeout,
   // Register port.
   input wire logic [1:0] reg_sel,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // Status and hand-off.
   input wire logic done_clear,
   input wire logic nvm_done_flag,
   input wire logic pm_read_req,
   input wire logic pm_done,
   input wire logic busy
);
   logic [31:0] up_cnt;
   logic [3:0] abort_cnt;
   logic ctl_wr;
   assign ctl_wr = reg_wr && reg_sel == NVM_SEL_CONTROL;
   ////////////////////////////////////////////////////////////
   // An abort reset makes a busy fall legal without a done flag, so it is remembered for a while.
   always_ff @(posedge clk)
   begin
      up_cnt <= (!nrst || por) ? 32'h0 : up_cnt + {31'h0, up_cnt < 32'hffff};
      abort_cnt <= !nrst ? 4'h0 : (external_reset_pin || watchdog_timeout) ? 4'hf : abort_cnt - {3'h0, abort_cnt != 4'h0};
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst || por);
   ////////////////////////////////////////////////////////////
   a_unlock_zero: assert property (reg_rd && reg_sel == NVM_SEL_UNLOCK |=> reg_rdata == 8'h00)
      else $error("unlock port read not zero");
   a_done_sticky: assert property (nvm_done_flag && !done_clear |=> nvm_done_flag)
      else $error("done flag dropped");
   a_busy_length: assert property ($rose(busy) |-> busy [*5])
      else $error("write cycle too short");
   a_wr_cause: assert property ($rose(busy) |-> $past(ctl_wr && reg_wdata[NVM_BIT_WR]))
      else $error("busy without trigger");
   a_code_no_read: assert property (ctl_wr && reg_wdata[0] && reg_wdata[7] |=> !pm_read_req [*3])
      else $error("read with code bit set");
   a_cfg_read: assert property (ctl_wr && reg_wdata[0] && reg_wdata[6] && !reg_wdata[7] && !busy
      |-> ##[1:3] pm_read_req)
      else $error("config read not handed on");
   a_done_at_end: assert property ($fell(busy) && abort_cnt == 4'h0 |-> ##[0:1] nvm_done_flag)
      else $error("no done flag");
   a_pwrt_block: assert property (up_cnt < PWRT_CYCLES |-> !busy)
      else $error("write during power-up");
endmodule // nvm_ctrl_checker

bind nvm_ctrl nvm_ctrl_checker #(.PWRT_CYCLES(PWRT_CYCLES)) u_chk (.clk(clk), .nrst(nrst), .por(por),
   .external_reset_pin(external_reset_pin), .watchdog_timeout(watchdog_timeout), .reg_sel(reg_sel),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .done_clear(done_clear),
   .nvm_done_flag(nvm_done_flag), .pm_read_req(pm_read_req), .pm_done(pm_done), .busy(busy));

//--- testbench/tb.sv
`timescale 1ns/10ps
`define check_eq(g, x) begin cmp_count++; if ((g) !== (x)) begin fail_count++; $display("wrong value %0t %h %h", $time, g, x); end end
// Bench driving the register port of the control block directly.
module tb;
   import nvm_pkg::*;
   logic clk, nrst, por, ext_rst, wdt_rst, reg_wr, reg_rd, done_clear, pm_done, done, pm_rd, pm_wr, pm_re, busy, rd_seen;
   logic [1:0] reg_sel, pm_sp;
   logic [7:0] reg_wdata, reg_rdata, a, d, e_m;
   logic [7:0] exp_q[$];
   int fail_count, cmp_count, n;
   ////////////////////////////////////////////////////////////
   // Short counts keep the run brief.
   nvm_ctrl #(.PWRT_CYCLES(40), .ERASE_CYCLES(4), .PROGRAM_CYCLES(4)) dut
   (
      .clk(clk), .nrst(nrst), .por(por), .external_reset_pin(ext_rst), .watchdog_timeout(wdt_rst),
      .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .done_clear(done_clear), .nvm_done_flag(done), .pm_read_req(pm_rd), .pm_write_req(pm_wr),
      .pm_space(pm_sp), .pm_row_erase(pm_re), .pm_done(pm_done), .busy(busy)
   );
   // Clock of 4 ns.
   always #2 clk = ~clk;
   // Results are compared half a cycle after their edge, once settled.
   always @(posedge clk) rd_seen <= reg_rd;
   always @(negedge clk)
   begin
      if (rd_seen || pm_rd || pm_wr)
      begin
         `check_eq(exp_q.size() != 0, 1'b1)
         e_m = exp_q.pop_front();
         `check_eq(rd_seen ? reg_rdata : {3'h0, pm_wr, pm_rd, pm_sp, pm_re}, e_m)
      end
   end
   ////////////////////////////////////////////////////////////
   // Each access leaves an idle cycle so a strobe never restarts in the edge that drops it.
   task automatic wr(input logic [1:0] s, input logic [7:0] v);
      reg_sel <= s;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [1:0] s, input logic [7:0] x);
      reg_sel <= s;
      reg_rd <= 1'b1;
      exp_q.push_back(x);
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic pulse(input bit clr);
      done_clear <= clr;
      pm_done <= !clr;
      @(posedge clk);
      done_clear <= 1'b0;
      pm_done <= 1'b0;
      @(posedge clk);
   endtask
   task automatic start(input logic [7:0] c);
      wr(NVM_SEL_UNLOCK, 8'h55);
      wr(NVM_SEL_UNLOCK, 8'haa);
      wr(NVM_SEL_CONTROL, c);
   endtask
   task automatic arm_write(input logic [7:0] p, input logic [7:0] v, input logic [7:0] c);
      wr(NVM_SEL_POINTER, p);
      wr(NVM_SEL_DATA, v);
      wr(NVM_SEL_CONTROL, c);
      start(c | 8'h02);
   endtask
   task automatic wait_idle();
      n = 0;
      while (busy !== 1'b0 && n < 60)
      begin
         @(negedge clk);
         n++;
      end
      if (n == 60)
      begin
         fail_count++;
         end_of_test();
      end
      @(posedge clk);
   endtask
   // The latch is overwritten first so a stale value cannot pass.
   task automatic ee_read(input logic [7:0] p, input logic [7:0] x);
      wr(NVM_SEL_POINTER, p);
      wr(NVM_SEL_DATA, ~x);
      wr(NVM_SEL_CONTROL, 8'h01);
      repeat (3) @(posedge clk);
      rd(NVM_SEL_DATA, x);
   endtask
   task automatic end_of_test();
      if (fail_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      clk = 1'b0;
      nrst = 1'b0;
      por = 1'b0;
      ext_rst = 1'b0;
      wdt_rst = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_sel = 2'h0;
      reg_wdata = 8'h00;
      done_clear = 1'b0;
      pm_done = 1'b0;
      n = $urandom(6391);
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(NVM_SEL_CONTROL, 8'h00);
      rd(NVM_SEL_UNLOCK, 8'h00);
      arm_write(8'h11, 8'h22, 8'h04);
      rd(NVM_SEL_CONTROL, 8'h04);
      repeat (40) @(posedge clk);
      wr(NVM_SEL_CONTROL, 8'h00);
      start(8'h06);
      rd(NVM_SEL_CONTROL, 8'h04);
      wr(NVM_SEL_UNLOCK, 8'haa);
      wr(NVM_SEL_UNLOCK, 8'h55);
      wr(NVM_SEL_CONTROL, 8'h06);
      wr(NVM_SEL_UNLOCK, 8'h55);
      wr(NVM_SEL_UNLOCK, 8'haa);
      wr(NVM_SEL_CONTROL, 8'h04);
      wr(NVM_SEL_CONTROL, 8'h06);
      rd(NVM_SEL_CONTROL, 8'h04);
      for (int i = 0; i < 3; i++)
      begin
         a = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
         d = 8'($urandom);
         arm_write(a, d, 8'h04);
         wait_idle();
         `check_eq(done, 1'b1)
         rd(NVM_SEL_CONTROL, 8'h04);
         pulse(1'b1);
         ee_read(a, d);
      end
      arm_write(a + 8'h01, ~d, 8'h04);
      wr(NVM_SEL_CONTROL, 8'h00);
      rd(NVM_SEL_CONTROL, 8'h02);
      wait_idle();
      pulse(1'b1);
      ee_read(a + 8'h01, ~d);
      for (int k = 0; k < 2; k++)
      begin
         if (k == 1)
            exp_q.push_back(8'h15);
         arm_write(8'($urandom) | 8'h01, 8'h5a, k ? 8'h94 : 8'h04);
         // The reset lands in mid-write, well clear of the last program cycle.
         repeat (2) @(posedge clk);
         ext_rst <= !k[0];
         wdt_rst <= k[0];
         repeat (3) @(posedge clk);
         ext_rst <= 1'b0;
         wdt_rst <= 1'b0;
         repeat (4) @(posedge clk);
         rd(NVM_SEL_CONTROL, k ? 8'h98 : 8'h08);
         rd(NVM_SEL_POINTER, 8'h00);
         rd(NVM_SEL_DATA, 8'h00);
      end
      wr(NVM_SEL_CONTROL, 8'h81);
      rd(NVM_SEL_CONTROL, 8'h80);
      exp_q.push_back(8'h0a);
      wr(NVM_SEL_CONTROL, 8'h41);
      pulse(1'b0);
      exp_q.push_back(8'h15);
      arm_write(8'h00, 8'h00, 8'h94);
      repeat (6) @(posedge clk);
      pulse(1'b0);
      wait_idle();
      rd(NVM_SEL_CONTROL, 8'h84);
      // A power-on pulse in mid-run must clear arm and done and restart the power-up timer.
      por <= 1'b1;
      repeat (2) @(posedge clk);
      por <= 1'b0;
      @(posedge clk);
      rd(NVM_SEL_CONTROL, 8'h00);
      `check_eq(done, 1'b0)
      arm_write(8'h33, 8'h44, 8'h04);
      rd(NVM_SEL_CONTROL, 8'h04);
      `check_eq(exp_q.size(), 0)
      end_of_test();
   end
endmodule // tb
